//--- core/nand_read_defines.svh
// Opcodes, timing and field constants for the NAND read host sequencer.
// Functional notes
// RULE1: Device powers up with 00h already latched.
// RULE2: Page read is 00h, five addresses, 30h.
// RULE3: Device busy during array read after 30h.
// RULE4: After 70h polling, reissue 00h before data.
// RULE5: Each strobe outputs next byte to page end.
// RULE6: Cache session starts with normal page read.
// RULE7: 31h fetches next page; status 00 then 10.
// RULE8: Random cache read ignores supplied column.
// RULE9: Continuation copies data to cache, busy period.
// RULE10: Cache output starts column 0 unless relocated.
// RULE11: 3Fh ends cache read; status 00 then 11.
// RULE12: Two-plane read: 00h+addr, 00h+addr, 30h.
// RULE13: Two-plane load sets status bit 6 done.
// RULE14: Select plane with 06h-E0h before strobing.
// RULE15: Never send 78h during two-plane read.
// RULE16: 05h, two columns, E0h relocates output column.
// RULE17: Column relocation only within loaded page.
// RULE18: 06h, two columns, three rows, E0h when ready.
// RULE19: Wait write_to_read_delay after E0h before strobing.
// RULE20: ID read with address 00h returns five bytes.
// RULE21: ID read at address 20h returns signature.
// RULE22: ID output mode lasts until next command.
// RULE23: Status mode lasts until next command; 00h restores.
// RULE24: Only defined opcodes are ever sent.
// RULE25: Wait for ready before next cache command.
`ifndef NAND_READ_DEFINES_SVH
`define NAND_READ_DEFINES_SVH
`define OP_READ_SETUP 8'h00
`define OP_READ_CONFIRM 8'h30
`define OP_CACHE_SEQ 8'h31
`define OP_CACHE_LAST 8'h3F
`define OP_COL_SETUP 8'h05
`define OP_PLANE_SETUP 8'h06
`define OP_COL_CONFIRM 8'hE0
`define OP_READ_ID 8'h90
`define OP_STATUS 8'h70
`define OP_STATUS_ENH 8'h78
`define ADDR_ID_CYCLES 3'h1
`define BUSY_DETECT_LIMIT 8'hFF
`define CTL_IDLE 5'h07
`define ADDR_ID_DEVICE 8'h00
`define ADDR_ID_ONFI 8'h20
`define ID_DEVICE_LEN 4'h5
`define ID_ONFI_LEN 4'h4
`define ADDR_FULL_CYCLES 3'h5
`define ADDR_COL_CYCLES 3'h2
`define STATUS_READY_BIT 6
`define WHR_NS 60
`define CLK_PERIOD_NS 10
`define WHR_CYCLES ((`WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HALF_CYCLES 2
`endif

//--- core/nand_read_pkg.sv
// Types shared by the NAND read host sequencer.
package nand_read_pkg;
  typedef enum logic [2:0] {
    REQ_PAGE_READ, REQ_CACHE_SEQ, REQ_CACHE_RANDOM, REQ_CACHE_LAST,
    REQ_TWO_PLANE, REQ_COL_OUT, REQ_PLANE_OUT, REQ_READ_ID
  } req_kind_e;
  typedef struct packed {
    req_kind_e kind;
    logic [39:0] addr;
    logic [39:0] addr2;
    logic [15:0] count;
  } host_req_s;
  typedef struct packed {
    logic cmdLatch;
    logic addrLatch;
    logic writeStrobeN;
    logic readStrobeN;
    logic chipEnableN;
  } nand_ctl_s;
endpackage : nand_read_pkg

//--- core/nand_read_host.sv
// Host-side sequencer that drives read command sequences into a NAND device.
`timescale 1ns/1ps
`default_nettype none
`include "nand_read_defines.svh"
module nand_read_host
  import nand_read_pkg::*;
#(
  parameter int WHR_COUNT = `WHR_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Request side.
  input wire logic reqValid,
  input wire host_req_s req,
  output logic reqReady,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done,
  // Device pins.
  output nand_ctl_s ctl,
  output logic [7:0] ioOut,
  output logic ioOe,
  input wire logic [7:0] ioIn,
  input wire logic readyBusyN
);
  // ------------------------------------------------------------------------
  // Pin synchronisers.
  // ------------------------------------------------------------------------
  logic rbMeta, rbSync;
  logic [7:0] ioMeta, ioSync;
  always_ff @(posedge clk_sys) begin
    rbMeta <= readyBusyN;
    rbSync <= rbMeta;
    ioMeta <= ioIn;
    ioSync <= ioMeta;
  end

  // ------------------------------------------------------------------------
  // Sequence engine.
  // ------------------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CMD, S_ADDR, S_BUSYW, S_WAITRDY, S_WHR, S_RDLO, S_RDHI
  } st_e;
  typedef enum logic [2:0] {
    P_CMD1, P_ADDR1, P_CMD2, P_ADDR2, P_CMD3, P_DATA
  } ph_e;
  st_e st;
  ph_e ph;
  host_req_s cur;
  logic [2:0] addrIdx;
  logic [2:0] strobeCnt;
  logic [7:0] waitCnt;
  logic [15:0] left;
  logic [7:0] busyByte;

  function automatic logic [7:0] addr_byte(input logic [39:0] a,
                                           input logic [2:0] i);
    addr_byte = a[{i, 3'b000} +: 8];
  endfunction : addr_byte

  // Opcode and address-count for each phase of the current request.
  logic [7:0] cmdOp;
  logic [2:0] addrLen;
  logic [39:0] addrSrc;
  logic waitsBusy;
  logic hasSecond;
  logic hasThird;
  wire idKind = cur.kind == REQ_READ_ID;
  wire colKind = cur.kind == REQ_COL_OUT;
  always_comb begin
    cmdOp = `OP_READ_SETUP;
    addrLen = `ADDR_FULL_CYCLES;
    addrSrc = cur.addr;
    hasSecond = 1'b1;
    hasThird = 1'b0;
    waitsBusy = 1'b1;
    unique case (cur.kind)
      REQ_PAGE_READ: cmdOp = (ph == P_CMD1) ? `OP_READ_SETUP
                                            : `OP_READ_CONFIRM; // RULE2 RULE4
      REQ_CACHE_SEQ: begin
        cmdOp = `OP_CACHE_SEQ; // RULE7
        hasSecond = 1'b0;
      end
      REQ_CACHE_RANDOM: cmdOp = (ph == P_CMD1) ? `OP_READ_SETUP
                                               : `OP_CACHE_SEQ; // RULE8
      REQ_CACHE_LAST: begin
        cmdOp = `OP_CACHE_LAST; // RULE11
        hasSecond = 1'b0;
      end
      REQ_TWO_PLANE: begin
        cmdOp = (ph == P_CMD3) ? `OP_READ_CONFIRM : `OP_READ_SETUP; // RULE12
        hasThird = 1'b1;
        if (ph == P_ADDR2) begin
          addrSrc = cur.addr2;
        end
      end
      REQ_COL_OUT: begin
        cmdOp = (ph == P_CMD1) ? `OP_COL_SETUP : `OP_COL_CONFIRM; // RULE16
        addrLen = `ADDR_COL_CYCLES;
        waitsBusy = 1'b0;
      end
      REQ_PLANE_OUT: begin
        // RULE18 RULE14
        cmdOp = (ph == P_CMD1) ? `OP_PLANE_SETUP : `OP_COL_CONFIRM;
        waitsBusy = 1'b0;
      end
      REQ_READ_ID: begin
        cmdOp = `OP_READ_ID; // RULE20
        addrLen = `ADDR_ID_CYCLES;
        hasSecond = 1'b0;
        waitsBusy = 1'b0;
      end
    endcase
  end

  wire strobeDone = strobeCnt == 3'(`STROBE_HALF_CYCLES - 1);
  wire lastAddr = addrIdx == 3'(addrLen - 3'h1);
  wire cmdOnly = (cur.kind == REQ_CACHE_SEQ) || (cur.kind == REQ_CACHE_LAST);
  // Only the second setup of a two-plane read takes a second address.
  wire needsAddr = !cmdOnly && (ph == P_CMD1 || (ph == P_CMD2 && hasThird));
  wire finalCmd = (ph == P_CMD3) || (ph == P_CMD2 && !hasThird) ||
                  (ph == P_CMD1 && !hasSecond && !idKind);
  wire [15:0] idLen = {12'h000, (cur.addr[7:0] == `ADDR_ID_ONFI)
                       ? `ID_ONFI_LEN : `ID_DEVICE_LEN}; // RULE21
  wire readyNow = rbSync; // RULE25
  assign reqReady = (st == S_IDLE) && readyNow; // RULE18

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= S_IDLE;
      ph <= P_CMD1;
      cur <= '0;
      addrIdx <= 3'h0;
      strobeCnt <= 3'h0;
      waitCnt <= 8'h00;
      left <= 16'h0000;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      done <= 1'b0;
      ctl <= `CTL_IDLE;
      ioOut <= 8'h00;
      ioOe <= 1'b0;
      busyByte <= 8'h00;
    end else begin
      rdValid <= 1'b0;
      done <= 1'b0;
      strobeCnt <= strobeDone ? 3'h0 : strobeCnt + 3'h1;
      unique case (st)
        S_IDLE: begin
          ctl <= `CTL_IDLE;
          ioOe <= 1'b0;
          strobeCnt <= 3'h0;
          if (reqValid && reqReady) begin
            cur <= req;
            ph <= P_CMD1;
            st <= S_CMD;
            ctl.chipEnableN <= 1'b0;
          end
        end
        S_CMD: begin
          ctl.cmdLatch <= 1'b1;
          ctl.addrLatch <= 1'b0;
          // Strobe is low in the first cycle; its rising edge latches the
          // byte, so the latch enable is held until the next phase.
          ctl.writeStrobeN <= strobeCnt != 3'h0; // RULE24
          ioOut <= cmdOp;
          ioOe <= 1'b1;
          if (strobeDone) begin
            addrIdx <= 3'h0;
            if (needsAddr) begin
              st <= S_ADDR;
              ph <= (ph == P_CMD1) ? P_ADDR1 : P_ADDR2;
            end else if (finalCmd) begin
              st <= waitsBusy ? S_BUSYW : S_WHR; // RULE3 RULE9
              waitCnt <= 8'h00;
              left <= cur.count;
            end else begin
              st <= S_ADDR;
              ph <= P_ADDR1;
            end
          end
        end
        S_ADDR: begin
          ctl.addrLatch <= 1'b1;
          ctl.cmdLatch <= 1'b0;
          ctl.writeStrobeN <= strobeCnt != 3'h0;
          ioOut <= idKind ? cur.addr[7:0] : addr_byte(addrSrc, addrIdx);
          if (strobeDone) begin
            addrIdx <= addrIdx + 3'h1;
            if (lastAddr) begin
              if (idKind) begin
                st <= S_WHR; // RULE22
                waitCnt <= 8'h00;
                left <= idLen;
              end else begin
                st <= S_CMD;
                ph <= (ph == P_ADDR1 && hasThird) ? P_CMD2
                    : (ph == P_ADDR2) ? P_CMD3 : P_CMD2;
              end
            end
          end
        end
        S_BUSYW: begin
          ioOe <= 1'b0;
          ctl.writeStrobeN <= 1'b1;
          ctl.cmdLatch <= 1'b0;
          ctl.addrLatch <= 1'b0;
          waitCnt <= waitCnt + 8'h01;
          if (!rbSync || waitCnt == `BUSY_DETECT_LIMIT) begin
            st <= S_WAITRDY; // RULE13
          end
        end
        S_WAITRDY: begin
          if (rbSync) begin
            st <= S_WHR; // RULE10 RULE6
            waitCnt <= 8'h00;
          end
        end
        S_WHR: begin
          ioOe <= 1'b0;
          ctl.writeStrobeN <= 1'b1;
          ctl.cmdLatch <= 1'b0;
          ctl.addrLatch <= 1'b0;
          waitCnt <= waitCnt + 8'h01;
          if (waitCnt >= 8'(WHR_COUNT)) begin // RULE19
            strobeCnt <= 3'h0;
            st <= (left == 16'h0000) ? S_IDLE : S_RDLO;
            done <= left == 16'h0000;
          end
        end
        S_RDLO: begin
          ctl.readStrobeN <= 1'b0;
          if (strobeDone) begin
            st <= S_RDHI;
          end
        end
        S_RDHI: begin
          ctl.readStrobeN <= 1'b1;
          // The synchronised bus lags the pin by two cycles.
          if (strobeDone) begin
            rdData <= ioSync; // RULE5 RULE17
            rdValid <= 1'b1;
          end
          if (strobeDone) begin
            left <= left - 16'h0001;
            st <= (left == 16'h0001) ? S_IDLE : S_RDLO;
            done <= left == 16'h0001;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------------------
  sequence confirm_sent_q;
    st == S_CMD && finalCmd && strobeDone && waitsBusy;
  endsequence
  property wait_busy_p;
    @(posedge clk_sys) disable iff (rst)
      confirm_sent_q |=> st == S_BUSYW;
  endproperty
  busy_wait_a: assert property (wait_busy_p) // RULE3
    else $error("confirm not followed by busy wait");
  no_strobe_busy_a: assert property ( // RULE25
      @(posedge clk_sys) disable iff (rst)
      st == S_WAITRDY && !rbSync |=> ctl.readStrobeN)
    else $error("read strobe while busy");
  whr_gap_a: assert property ( // RULE19
      @(posedge clk_sys) disable iff (rst)
      $rose(st == S_WHR) |-> (st != S_RDLO)[*6])
    else $error("data strobed too soon after command");
  no_enh_status_a: assert property ( // RULE15
      @(posedge clk_sys) disable iff (rst)
      ioOe && ctl.cmdLatch |-> ioOut != `OP_STATUS_ENH)
    else $error("enhanced status opcode sent");
  cmd_wr_a: assert property ( // RULE2
      @(posedge clk_sys) disable iff (rst)
      !ctl.writeStrobeN |-> ioOe && (ctl.cmdLatch ^ ctl.addrLatch))
    else $error("write strobe without latch");
  id_len_a: assert property ( // RULE20
      @(posedge clk_sys) disable iff (rst)
      st == S_ADDR && idKind && strobeDone
      |=> left inside {16'h0004, 16'h0005})
    else $error("id length wrong");
  ready_gate_a: assert property ( // RULE18
      @(posedge clk_sys) disable iff (rst)
      st == S_IDLE && reqValid && !rbSync |=> st == S_IDLE)
    else $error("request taken while busy");
  plane_cmd_a: assert property ( // RULE14
      @(posedge clk_sys) disable iff (rst)
      st == S_CMD && cur.kind == REQ_PLANE_OUT && ph == P_CMD1 &&
      strobeDone |-> ioOut == `OP_PLANE_SETUP && ctl.cmdLatch)
    else $error("plane select opcode wrong");
endmodule : nand_read_host
`default_nettype wire

//--- verif/nand_device_model.sv
// Behavioural model of the NAND device that answers the read host.
`timescale 1ns/1ps
`default_nettype none
module nand_device_model
  import nand_read_pkg::*;
#(
  parameter int ARRAY_NS = 400,
  parameter int CACHE_NS = 300,
  parameter int WHR_NS = 60,
  parameter int PLANE_BIT = 0,
  // Identification bytes; the value is arbitrary.
  parameter logic [39:0] ID_CODE = 40'hA1_B2C3_D4E5
) (
  // Host pins.
  input wire nand_ctl_s ctl,
  input wire logic [7:0] ioOut,
  input wire logic ioOe,
  // Device pins.
  output logic [7:0] ioIn,
  output logic readyBusyN,
  output logic protoErr
);
  localparam logic [31:0] ONFI_SIG = 32'h4F4E_4649;
  logic [7:0] cmd = 8'h00;
  logic [7:0] dq = 8'h00;
  logic [39:0] adr, first;
  logic [23:0] dataPg, cachePg;
  logic [23:0] pln [2];
  logic endRd = 1'b1;
  logic twoPl = 1'b0;
  int nAdr = 0, col = 0, mode = 0, pick = 0;
  realtime lastWe = 0;
  wire latchOn = !ctl.chipEnableN && ioOe;
  // A deselected device does not show its last byte.
  assign ioIn = ctl.chipEnableN ? ~dq : dq;
  initial begin
    readyBusyN = 1'b1;
    protoErr = 1'b0;
  end
  task automatic goBusy(input int ns);
    readyBusyN <= 1'b0;
    readyBusyN <= #(ns) 1'b1;
  endtask : goBusy
  always @(posedge ctl.writeStrobeN) begin
    lastWe = $realtime;
    if (latchOn && ctl.addrLatch) begin
      adr[8*nAdr +: 8] = ioOut;
      nAdr = nAdr + 1;
      pick = 0;
      if (cmd == 8'h90) mode = (ioOut == 8'h20) ? 2 : 1;
    end else if (latchOn && ctl.cmdLatch) begin
      if (!readyBusyN) protoErr = 1'b1;
      mode = 0;
      case (ioOut)
        8'h00: begin
          twoPl = (cmd == 8'h00 && nAdr == 5);
          first = adr;
        end
        8'h30: begin
          dataPg = adr[39:16];
          cachePg = adr[39:16];
          col = adr[15:0];
          if (twoPl) pln[first[16+PLANE_BIT]] = first[39:16];
          pln[adr[16+PLANE_BIT]] = adr[39:16];
          endRd = 1'b1;
          goBusy(ARRAY_NS);
        end
        8'h31, 8'h3F: begin
          cachePg = dataPg;
          col = 0;
          endRd = ioOut[3];
          if (ioOut == 8'h31) dataPg = (cmd == 8'h00) ? adr[39:16] : dataPg + 24'h1;
          goBusy(CACHE_NS);
        end
        8'hE0: begin
          col = adr[15:0];
          if (cmd == 8'h06) cachePg = pln[adr[16+PLANE_BIT]];
        end
        8'h70: mode = 3;
        8'h05, 8'h06, 8'h90: ;
        default: protoErr = 1'b1;
      endcase
      cmd = ioOut;
      nAdr = 0;
    end
  end
  always @(negedge ctl.readStrobeN) begin
    if ($realtime - lastWe < WHR_NS) protoErr = 1'b1;
    case (mode)
      1: dq = ID_CODE[39-8*pick -: 8];
      2: dq = ONFI_SIG[31-8*pick -: 8];
      3: dq = {1'b1, readyBusyN, readyBusyN & endRd, 5'h00};
      default: begin
        dq = {cachePg[3:0], 4'h0} + col[7:0];
        col = col + 1;
      end
    endcase
    pick = pick + 1;
  end
endmodule : nand_device_model
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the NAND read host sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import nand_read_pkg::*;
;
  typedef struct {
    host_req_s req;
    logic [39:0] seq;
  } row_s;
  localparam logic [39:0] ID_CODE = 40'h5A_6B7C_8D9E; // Arbitrary value.
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  host_req_s req = '0;
  logic reqReady, rdValid, done, ioOe, readyBusyN, protoErr;
  logic [7:0] rdData, ioOut, ioIn;
  nand_ctl_s ctl;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  row_s rows [8] = '{
    '{'{REQ_PAGE_READ, 40'h00_0005_0003, 40'h0, 16'h0004}, 40'h53},
    '{'{REQ_COL_OUT, 40'h00_0000_0020, 40'h0, 16'h0003}, 40'h70},
    '{'{REQ_CACHE_SEQ, 40'h0, 40'h0, 16'h0002}, 40'h50},
    '{'{REQ_CACHE_RANDOM, 40'h00_0009_0044, 40'h0, 16'h0002}, 40'h60},
    '{'{REQ_CACHE_LAST, 40'h0, 40'h0, 16'h0003}, 40'h90},
    '{'{REQ_TWO_PLANE, 40'h00_0002_0000, 40'h00_0003_0000, 16'h0000}, 40'h0},
    '{'{REQ_PLANE_OUT, 40'h00_0003_0001, 40'h0, 16'h0002}, 40'h31},
    '{'{REQ_PLANE_OUT, 40'h00_0002_0004, 40'h0, 16'h0002}, 40'h24}
  };
  nand_read_host i_dut (
    .clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .done(done),
    .ctl(ctl), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
    .readyBusyN(readyBusyN)
  );
  nand_device_model #(.ID_CODE(ID_CODE)) i_dev (
    .ctl(ctl), .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn),
    .readyBusyN(readyBusyN), .protoErr(protoErr)
  );
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  task automatic sendReq(input host_req_s r);
    int k;
    k = 0;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    req <= r;
    do begin
      @(negedge clk_sys);
      k++;
    end while (reqReady !== 1'b1 && k < 3000);
    @(posedge clk_sys);
    reqValid <= 1'b0;
  endtask : sendReq
  task automatic runReq(input host_req_s r, input logic [39:0] seq, input bit inc);
    int n, k;
    logic [7:0] e;
    n = 0;
    k = 0;
    sendReq(r);
    while (done !== 1'b1 && k < 3000) begin
      @(negedge clk_sys);
      k++;
      if (rdValid === 1'b1) begin
        e = inc ? seq[7:0] + 8'(n) : seq[39-8*n -: 8];
        check({8'h00, rdData}, {8'h00, e});
        n++;
      end
    end
    check({15'h0, done}, 16'h0001);
    check(16'(n), r.count);
  endtask : runReq
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check(16'(ctl), 16'h0007);
    check({15'h0, ioOe}, 16'h0000);
    $display("test reset done");
    foreach (rows[i]) begin
      runReq(rows[i].req, rows[i].seq, 1'b1);
      $display("test row %0d done", i);
    end
    // Reset lands while the device is still busy on a page fetch.
    sendReq('{REQ_PAGE_READ, 40'h00_0001_0000, 40'h0, 16'h0002});
    repeat (20) @(posedge clk_sys);
    rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check(16'(ctl), 16'h0007);
    check({15'h0, reqReady}, 16'h0000);
    runReq('{REQ_READ_ID, 40'h0, 40'h0, 16'h0005}, ID_CODE, 1'b0);
    runReq('{REQ_READ_ID, 40'h20, 40'h0, 16'h0004}, 40'h4F_4E46_4900, 1'b0);
    runReq('{REQ_PAGE_READ, 40'h00_0007_0000, 40'h0, 16'h0002}, 40'h70, 1'b1);
    check({15'h0, protoErr}, 16'h0000);
    $display("test abort and id done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
